// ==== rer_map.svh ====
/*
 * Register map constants of the regulator enable bank: offsets, bit positions,
 * reset values and the slot code that hands a regulator to the host.
 * Assumes inclusion by bare name from the top module.
 */
`ifndef RER_MAP_SVH
`define RER_MAP_SVH

`define RER_ENABLE_OFFSET 8'h09
`define RER_BOOST_OFFSET 8'h0A
`define RER_ENABLE_RESET 3'h0
`define RER_BOOST_RESET 8'h00
`define RER_FIRST_BIT 0
`define RER_SECOND_BIT 1
`define RER_THIRD_BIT 2
`define RER_SLOT_HOST 3'h0
`define RER_BYTE_BITS 4'h8

`endif

// ==== rer_pkg.sv ====
/*
 * Types of the regulator enable bank: serial-port states, slot carrier and
 * the state records of the synchroniser and the top module.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rer_pkg;

	typedef enum logic [3:0] {
		RER_IDLE,
		RER_ADDR,
		RER_ADDR_ACK,
		RER_REG,
		RER_REG_ACK,
		RER_WDATA,
		RER_WDATA_ACK,
		RER_RDATA,
		RER_RACK
	} rer_i2c_state_t;

	typedef struct packed {
		logic [2:0] third_linear_reg_slot;
		logic [2:0] second_linear_reg_slot;
		logic [2:0] first_linear_reg_slot;
	} rer_slots_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} rer_sync_state_t;

	typedef struct packed {
		rer_i2c_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rw;
		logic nack;
		logic scl_d;
		logic sda_d;
		logic sda_oe;
		logic [2:0] enable;
		logic [7:0] boost;
		logic [2:0] lin_on;
		logic step_on;
	} rer_top_state_t;

endpackage

// ==== rer_pin_sync.sv ====
/*
 * Three-flop pin synchroniser; the output follows once stages two and three
 * agree, which also drops single-cycle glitches.
 * Assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/1ps

module rer_pin_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic pin_sync
);

	rer_pkg::rer_sync_state_t s_r;
	rer_pkg::rer_sync_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = pin_in;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (s_r.s2 == s_r.s3) begin
			s_nxt.q = s_r.s3;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin_sync = s_r.q;

endmodule

// ==== rer_top.sv ====
/*
 * Regulator enable bank: serial two-wire slave holding the regulator enable
 * and boost enable registers, and the enable outputs derived from them.
 * Assumes slot fields and sequencer requests come from logic on mclk; the
 * two-wire pins come from outside and are synchronised here.
 */
`timescale 1ns/1ps
`include "rer_map.svh"

module rer_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input rer_pkg::rer_slots_t slots,
	input wire logic [2:0] seq_linear_reg_req,
	output logic [2:0] linear_reg_en,
	output logic step_up_en
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration check
	generate
		if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
			$error("device address lies in a reserved two-wire range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// read value of a register pointer; unmapped offsets read zero
	function automatic logic [7:0] rd_reg(
		input logic [7:0] ptr,
		input logic [2:0] en,
		input logic [7:0] bst
	);
		logic [7:0] v;
		v = 8'h00;
		case (ptr)
			`RER_ENABLE_OFFSET: v = {5'h00, en};
			`RER_BOOST_OFFSET: v = bst;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// host bit rules while slot is 000, sequencer otherwise
	function automatic logic eff_on(
		input logic [2:0] slot,
		input logic host_bit,
		input logic seq_req
	);
		return (slot == `RER_SLOT_HOST) ? host_bit : seq_req;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic scl_s;
	logic sda_s;

	rer_pin_sync #(.RST_VAL(1'b1)) u_scl_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(scl_in),
		.pin_sync(scl_s)
	);

	rer_pin_sync #(.RST_VAL(1'b1)) u_sda_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(sda_in),
		.pin_sync(sda_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// state update
	rer_pkg::rer_top_state_t s_r;
	rer_pkg::rer_top_state_t s_nxt;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] rd_val;

	always_comb begin
		s_nxt = s_r;
		scl_rise = scl_s & ~s_r.scl_d;
		scl_fall = ~scl_s & s_r.scl_d;
		bus_start = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
		bus_stop = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;
		rd_val = rd_reg(s_r.ptr, s_r.enable, s_r.boost);
		s_nxt.scl_d = scl_s;
		s_nxt.sda_d = sda_s;

		if (bus_start) begin
			s_nxt.st = rer_pkg::RER_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end else if (bus_stop) begin
			s_nxt.st = rer_pkg::RER_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else begin
			case (s_r.st)
				rer_pkg::RER_IDLE: begin
					s_nxt.sda_oe = 1'b0;
				end
				rer_pkg::RER_ADDR, rer_pkg::RER_REG, rer_pkg::RER_WDATA: begin
					if (scl_rise) begin
						s_nxt.sh = {s_r.sh[6:0], sda_s};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall && s_r.cnt == `RER_BYTE_BITS) begin
						s_nxt.cnt = 4'h0;
						s_nxt.sda_oe = 1'b1;
						if (s_r.st == rer_pkg::RER_ADDR) begin
							if (s_r.sh[7:1] == DEV_ADDR) begin
								s_nxt.rw = s_r.sh[0];
								s_nxt.st = rer_pkg::RER_ADDR_ACK;
							end else begin
								s_nxt.sda_oe = 1'b0;
								s_nxt.st = rer_pkg::RER_IDLE;
							end
						end else if (s_r.st == rer_pkg::RER_REG) begin
							s_nxt.ptr = s_r.sh;
							s_nxt.st = rer_pkg::RER_REG_ACK;
						end else begin
							// host write of the enable or boost register, chosen by the pointer
							case (s_r.ptr)
								`RER_ENABLE_OFFSET: s_nxt.enable = s_r.sh[2:0];
								`RER_BOOST_OFFSET: s_nxt.boost = s_r.sh;
								default: s_nxt.enable = s_r.enable;
							endcase
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = rer_pkg::RER_WDATA_ACK;
						end
					end
				end
				rer_pkg::RER_ADDR_ACK: begin
					if (scl_fall) begin
						s_nxt.cnt = 4'h0;
						if (s_r.rw) begin
							s_nxt.sh = rd_val;
							s_nxt.sda_oe = ~rd_val[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = rer_pkg::RER_RDATA;
						end else begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st = rer_pkg::RER_REG;
						end
					end
				end
				rer_pkg::RER_REG_ACK, rer_pkg::RER_WDATA_ACK: begin
					if (scl_fall) begin
						s_nxt.cnt = 4'h0;
						s_nxt.sda_oe = 1'b0;
						s_nxt.st = rer_pkg::RER_WDATA;
					end
				end
				rer_pkg::RER_RDATA: begin
					if (scl_rise) begin
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_r.cnt == `RER_BYTE_BITS) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st = rer_pkg::RER_RACK;
						end else begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.sh[6];
						end
					end
				end
				rer_pkg::RER_RACK: begin
					if (scl_rise) begin
						s_nxt.nack = sda_s;
					end else if (scl_fall) begin
						s_nxt.cnt = 4'h0;
						if (!s_r.nack) begin
							s_nxt.sh = rd_val;
							s_nxt.sda_oe = ~rd_val[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = rer_pkg::RER_RDATA;
						end else begin
							s_nxt.st = rer_pkg::RER_IDLE;
						end
					end
				end
				default: begin
					s_nxt.sda_oe = 1'b0;
					s_nxt.st = rer_pkg::RER_IDLE;
				end
			endcase
		end

		// regulator enables
		s_nxt.lin_on[`RER_THIRD_BIT] = eff_on(slots.third_linear_reg_slot,
			s_r.enable[`RER_THIRD_BIT], seq_linear_reg_req[`RER_THIRD_BIT]);
		s_nxt.lin_on[`RER_SECOND_BIT] = eff_on(slots.second_linear_reg_slot,
			s_r.enable[`RER_SECOND_BIT], seq_linear_reg_req[`RER_SECOND_BIT]);
		s_nxt.lin_on[`RER_FIRST_BIT] = eff_on(slots.first_linear_reg_slot,
			s_r.enable[`RER_FIRST_BIT], seq_linear_reg_req[`RER_FIRST_BIT]);
		s_nxt.step_on = |s_r.boost;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
			// pins idle high; avoids a false edge at release
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.enable <= `RER_ENABLE_RESET;
			s_r.boost <= `RER_BOOST_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign sda_out = 1'b0;
	assign sda_oe = s_r.sda_oe;
	assign linear_reg_en = s_r.lin_on;
	assign step_up_en = s_r.step_on;

endmodule

// ==== rer_monitor.sv ====
/* port checker of the regulator enable bank
   assumes a bind onto rer_top */
`timescale 1ns/1ps
module rer_monitor (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input rer_pkg::rer_slots_t slots,
	input wire logic [2:0] seq_linear_reg_req,
	input wire logic [2:0] linear_reg_en,
	input wire logic step_up_en
);
	logic [2:0] fr;
	assign fr = {|slots.third_linear_reg_slot, |slots.second_linear_reg_slot,
		|slots.first_linear_reg_slot};
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	property p_seq; fr != 3'h0 |=> (linear_reg_en & $past(fr)) == $past(seq_linear_reg_req & fr);
	endproperty
	property p_host;
		$changed(linear_reg_en) && !$past(sys_rst, 2) && $past(slots) == $past(slots, 2)
			&& $past(seq_linear_reg_req) == $past(seq_linear_reg_req, 2) |-> !scl_in;
	endproperty
	property p_boost; $changed(step_up_en) |-> !scl_in; endproperty
	property p_ack; $rose(sda_oe) |-> !scl_in; endproperty
	property p_rel; $fell(sda_oe) |-> !scl_in; endproperty
	property p_stand; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
	property p_rst; $fell(sys_rst) |-> linear_reg_en == 3'h0 && !step_up_en; endproperty
	property p_od; sda_out == 1'b0; endproperty
	a_seq: assert property (p_seq) else $error("sequencer path wrong");
	a_host: assert property (p_host) else $error("host bit moved off bus");
	a_boost: assert property (p_boost) else $error("boost moved off bus");
	a_ack: assert property (p_ack) else $error("drive began with clock high");
	a_rel: assert property (p_rel) else $error("release with clock high");
	a_stand: assert property (p_stand) else $error("data moved with clock high");
	a_rst: assert property (p_rst) else $error("outputs on after reset");
	a_od: assert property (p_od) else $error("data drive not low");
endmodule
bind rer_top rer_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .slots(slots),
	.seq_linear_reg_req(seq_linear_reg_req), .linear_reg_en(linear_reg_en),
	.step_up_en(step_up_en));

// ==== rer_host_model.sv ====
/* two-wire host: drives the clock, pulls data low
   assumes sda_line is the wired level with pull-up */
`timescale 1ns/1ps
module rer_host_model (
	input wire logic mclk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wt();
		repeat (12) @(negedge mclk);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		wt();
		scl = 1'b1;
		wt();
		r = sda_line;
		scl = 1'b0;
		wt();
	endtask
	task automatic put_start();
		sda_low = 1'b0;
		wt();
		scl = 1'b1;
		wt();
		sda_low = 1'b1;
		wt();
		scl = 1'b0;
		wt();
	endtask
	task automatic put_stop();
		sda_low = 1'b1;
		wt();
		scl = 1'b1;
		wt();
		sda_low = 1'b0;
		wt();
	endtask
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
		output logic ak);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(m, ak);
	endtask
endmodule

// ==== rer_top_tb.sv ====
/* bench of the regulator enable bank
   assumes the host model and checker beside it */
`timescale 1ns/1ps
module rer_top_tb;
	localparam logic [6:0] DEV = 7'h2A;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	rer_pkg::rer_slots_t slots = '0;
	logic [2:0] seq = 3'h0;
	logic scl, low, sda_out, sda_oe, step;
	logic [2:0] en;
	logic [7:0] q, b0, b1;
	logic [31:0] ru;
	logic ak_m;
	int num_errors = 0;
	int tests_run = 0;
	wire sda = !(low || (sda_oe && !sda_out));
	rer_top #(.DEV_ADDR(DEV)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .slots(slots), .seq_linear_reg_req(seq),
		.linear_reg_en(en), .step_up_en(step));
	rer_host_model u_host (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_low(low));
	initial begin
		forever #20 mclk = !mclk;
	end
	////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic tx(input logic [7:0] d, input logic nak);
		logic ak;
		u_host.xfer(d, 1'b1, q, ak);
		chk({7'h0, ak}, {7'h0, nak});
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		u_host.put_start();
		tx({DEV, 1'b0}, 1'b0);
		tx(p, 1'b0);
		tx(d, 1'b0);
		u_host.put_stop();
	endtask
	task automatic rd(input logic [7:0] p);
		u_host.put_start();
		tx({DEV, 1'b0}, 1'b0);
		tx(p, 1'b0);
		u_host.put_start();
		tx({DEV, 1'b1}, 1'b0);
		tx(8'hFF, 1'b1);
		u_host.put_stop();
	endtask
	function automatic logic [2:0] exp_en(input logic [7:0] rg);
		exp_en[0] = slots.first_linear_reg_slot == 3'h0 ? rg[0] : seq[0];
		exp_en[1] = slots.second_linear_reg_slot == 3'h0 ? rg[1] : seq[1];
		exp_en[2] = slots.third_linear_reg_slot == 3'h0 ? rg[2] : seq[2];
	endfunction
	////////////////////////////////////////
	initial begin
		ru = $urandom(17631);
		repeat (10) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (5) @(negedge mclk);
		chk({4'h0, step, en}, 8'h00);
		rd(8'h09);
		chk(q, 8'h00);
		rd(8'h0A);
		chk(q, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(8'h0A, 8'h01 << i);
			chk({7'h0, step}, 8'h01);
		end
		wr(8'h0A, 8'h00);
		chk({7'h0, step}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			ru = $urandom;
			slots = ru[8:0] & {{3{ru[9]}}, {3{ru[10]}}, {3{ru[11]}}};
			seq = ru[14:12];
			b0 = ru[23:16];
			b1 = ru[31:24] & {8{i != 0}};
			wr(8'h09, b0);
			wr(8'h0A, b1);
			rd(8'h09);
			chk(q, {5'h0, b0[2:0]});
			rd(8'h0A);
			chk(q, b1);
			chk({4'h0, step, en}, {4'h0, |b1, exp_en(b0)});
		end
		u_host.put_start();
		tx({DEV, 1'b0}, 1'b0);
		tx(8'h09, 1'b0);
		tx(b1, 1'b0);
		tx(b0, 1'b0);
		u_host.put_stop();
		chk({4'h0, step, en}, {4'h0, |b0, exp_en(b1)});
		u_host.put_start();
		tx({DEV, 1'b0}, 1'b0);
		tx(8'h09, 1'b0);
		u_host.put_start();
		tx({DEV, 1'b1}, 1'b0);
		u_host.xfer(8'hFF, 1'b0, q, ak_m);
		chk(q, {5'h0, b1[2:0]});
		tx(8'hFF, 1'b1);
		chk(q, b0);
		u_host.put_stop();
		wr(8'h0B, 8'hFF);
		rd(8'h0B);
		chk(q, 8'h00);
		u_host.put_start();
		tx({DEV ^ 7'h01, 1'b0}, 1'b1);
		u_host.put_stop();
		sys_rst = 1'b1;
		repeat (2) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (5) @(negedge mclk);
		chk({4'h0, step, en}, {5'h0, exp_en(8'h00)});
		rd(8'h09);
		chk(q, 8'h00);
		rd(8'h0A);
		chk(q, 8'h00);
		stop_test();
	end
	initial begin
		repeat (85000) @(posedge mclk);
		num_errors++;
		stop_test();
	end
endmodule
